// File: utl_map.vh
// Constants for the UTMI transmit and byte-clock block.
// Assumes the 100 MHz core clock stands in for the PHY bit-rate clock.
`ifndef UTL_MAP_VH
`define UTL_MAP_VH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UTL_CORE_MHZ        100
`define UTL_START_US        5600
`define UTL_SETTLE_US       1400
`define UTL_START_CYC       (`UTL_START_US * `UTL_CORE_MHZ)
`define UTL_SETTLE_CYC      (`UTL_SETTLE_US * `UTL_CORE_MHZ)
`define UTL_FS_BIT_CLKS     5
`define UTL_FS_BYTE_CLKS    40
`define UTL_FS_STUF1_CLKS   45
`define UTL_FS_STUF2_CLKS   50
// ----------------------------------------------------------------------
// Line coding
// ----------------------------------------------------------------------
`define UTL_SYNC_BYTE       8'h80
`define UTL_STUFF_RUN       6
`define UTL_EOP_BITS        2
// ----------------------------------------------------------------------
// Transmit states
// ----------------------------------------------------------------------
`define UTL_ST_RESET        3'h0
`define UTL_ST_WAIT         3'h1
`define UTL_ST_SYNC         3'h2
`define UTL_ST_DATA         3'h3
`define UTL_ST_EOP          3'h4
`endif

// File: utl_tx_link.v
// UTMI transmit path, byte clock enable and receive strobe pacing.
// Assumes SIE inputs are synchronous to core_clk; line side is bit serial.
`timescale 1ns/1ps
`include "utl_map.vh"
module utl_tx_link
#(
  parameter START_CYC  = `UTL_START_CYC,
  parameter SETTLE_CYC = `UTL_SETTLE_CYC
)
(
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       suspend_n,
  input  wire       xcvr_select,
  input  wire [7:0] data_in,
  input  wire       tx_valid,
  input  wire       rx_byte_ready,
  input  wire [7:0] rx_byte,
  input  wire       rx_packet,
  output reg  [7:0] data_out,
  output reg        data_oe,
  output wire       tx_ready,
  output reg        rx_active,
  output reg        rx_valid,
  output reg        phy_byte_clock,
  output reg        clock_locked,
  output reg        line_bit,
  output reg        line_se0,
  output reg        line_oe
);

// ----------------------------------------------------------------------
// Byte clock start-up after suspend
// ----------------------------------------------------------------------
// The analog PLL is outside this block; the counters model its start and
// settle windows; the transmitter waits out only the start window, not clock_locked, and the receive side waits for neither.
reg [31:0] start_cnt;
reg        clock_run;
always @(posedge core_clk)
begin
  if (!rst_n || !suspend_n)
  begin
    start_cnt      <= 32'h0;
    clock_run      <= 1'b0;
    clock_locked   <= 1'b0;
    phy_byte_clock <= 1'b0;
  end
  else if (!clock_run)
  begin
    start_cnt <= start_cnt + 32'h1;
    if (start_cnt >= START_CYC - 1)
    begin
      clock_run <= 1'b1;
      start_cnt <= 32'h0;
    end
  end
  else
  begin
    phy_byte_clock <= ~phy_byte_clock;
    if (!clock_locked)
    begin
      start_cnt <= start_cnt + 32'h1;
      if (start_cnt >= SETTLE_CYC - 1)
        clock_locked <= 1'b1;
    end
  end
end

// ----------------------------------------------------------------------
// Bit pacing: one tick per line bit
// ----------------------------------------------------------------------
reg [2:0] bit_div;
wire      bit_tick = xcvr_select ? (bit_div == `UTL_FS_BIT_CLKS - 1)
                                 : 1'b1;
always @(posedge core_clk)
begin
  if (!rst_n || !xcvr_select || bit_tick)
    bit_div <= 3'h0;
  else
    bit_div <= bit_div + 3'h1;
end

// ----------------------------------------------------------------------
// Transmit state machine
// ----------------------------------------------------------------------
reg  [2:0] state;
reg  [2:0] next_state;
reg  [7:0] shift;
reg  [7:0] next_shift;
reg  [7:0] hold;
reg  [7:0] next_hold;
reg        hold_full;
reg        next_hold_full;
reg  [2:0] bit_idx;
reg  [2:0] next_bit_idx;
reg  [2:0] ones;
reg  [2:0] next_ones;
reg        stuff_pend;
reg        next_stuff_pend;
reg        need_byte;
reg        next_need_byte;
reg        nrzi;
reg        next_nrzi;
reg        next_line_bit;
reg        next_line_se0;
reg        next_line_oe;
wire       in_frame = (state == `UTL_ST_SYNC) || (state == `UTL_ST_DATA);
wire       cur_bit  = shift[0];
wire       take     = tx_ready && tx_valid;
wire       last_bit = bit_tick && !stuff_pend && (bit_idx == 3'h7);

// A byte is asked for once per byte time, at bit 6 of a data byte (the first one from the start of sync), so the ready pulse
// comes early in full speed and just in time in high speed.
// Gating by tx_valid keeps ready low from the cycle the SIE lets go.
assign tx_ready = in_frame && need_byte && tx_valid;

// ----------------------------------------------------------------------
// Transmit next-state logic
// ----------------------------------------------------------------------
// A byte taken on the very edge that empties the shifter goes straight
// into it; any earlier byte waits in the holding register.
always @*
begin
  next_state      = state;
  next_shift      = shift;
  next_hold       = hold;
  next_hold_full  = hold_full;
  next_bit_idx    = bit_idx;
  next_ones       = ones;
  next_stuff_pend = stuff_pend;
  next_need_byte  = need_byte;
  next_nrzi       = nrzi;
  next_line_bit   = line_bit;
  next_line_se0   = line_se0;
  next_line_oe    = line_oe;
  case (state)
    `UTL_ST_RESET:
      next_state = `UTL_ST_WAIT;
    `UTL_ST_WAIT:
    begin
      next_line_oe  = 1'b0;
      next_line_se0 = 1'b0;
      next_line_bit = 1'b1;
      if (tx_valid && clock_run)
      begin
        next_state      = `UTL_ST_SYNC;
        next_shift      = `UTL_SYNC_BYTE;
        next_bit_idx    = 3'h0;
        next_ones       = 3'h0;
        next_stuff_pend = 1'b0;
        next_hold_full  = 1'b0;
        next_need_byte  = 1'b1;
        next_nrzi       = 1'b1;
      end
    end
    `UTL_ST_SYNC, `UTL_ST_DATA:
    begin
      if (take && !last_bit)
      begin
        next_hold      = data_in;
        next_hold_full = 1'b1;
      end
      if (take)
        next_need_byte = 1'b0;
      if (bit_tick)
      begin
        next_line_oe = 1'b1;
        if (stuff_pend)
        begin
          next_nrzi       = ~nrzi;
          next_line_bit   = ~nrzi;
          next_stuff_pend = 1'b0;
          next_ones       = 3'h0;
        end
        else
        begin
          next_line_bit   = cur_bit ? nrzi : ~nrzi;
          next_nrzi       = cur_bit ? nrzi : ~nrzi;
          next_ones       = cur_bit ? ones + 3'h1 : 3'h0;
          next_stuff_pend = cur_bit && (ones == `UTL_STUFF_RUN - 1);
          next_shift      = {1'b0, shift[7:1]};
          next_bit_idx    = bit_idx + 3'h1;
          if (bit_idx == 3'h6 && state == `UTL_ST_DATA && tx_valid)
            next_need_byte = 1'b1;
        end
      end
      if (last_bit)
      begin
        next_bit_idx = 3'h0;
        if (hold_full)
        begin
          next_state     = `UTL_ST_DATA;
          next_shift     = hold;
          next_hold_full = 1'b0;
        end
        else if (take)
        begin
          next_state = `UTL_ST_DATA;
          next_shift = data_in;
        end
        else
        begin
          next_state     = `UTL_ST_EOP;
          next_need_byte = 1'b0;
        end
      end
    end
    `UTL_ST_EOP:
    begin
      next_need_byte = 1'b0;
      if (bit_tick)
      begin
        next_bit_idx  = bit_idx + 3'h1;
        next_line_se0 = (bit_idx < `UTL_EOP_BITS);
        next_line_bit = 1'b1;
        if (bit_idx == `UTL_EOP_BITS + 1)
          next_state = `UTL_ST_WAIT;
      end
    end
    default:
      next_state = `UTL_ST_RESET;
  endcase
end

// ----------------------------------------------------------------------
// Transmit registers
// ----------------------------------------------------------------------
always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    state      <= `UTL_ST_RESET;
    shift      <= 8'h0;
    hold       <= 8'h0;
    hold_full  <= 1'b0;
    bit_idx    <= 3'h0;
    ones       <= 3'h0;
    stuff_pend <= 1'b0;
    need_byte  <= 1'b0;
    nrzi       <= 1'b1;
  end
  else
  begin
    state      <= next_state;
    shift      <= next_shift;
    hold       <= next_hold;
    hold_full  <= next_hold_full;
    bit_idx    <= next_bit_idx;
    ones       <= next_ones;
    stuff_pend <= next_stuff_pend;
    need_byte  <= next_need_byte;
    nrzi       <= next_nrzi;
  end
end

// ----------------------------------------------------------------------
// Line driver outputs
// ----------------------------------------------------------------------
// The end-of-packet keeps the driver on for two idle bit ticks after the two
// single-ended zero bits, so the line leaves the packet at the J level.
always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    line_bit <= 1'b1;
    line_se0 <= 1'b0;
    line_oe  <= 1'b0;
  end
  else
  begin
    line_bit <= next_line_bit;
    line_se0 <= next_line_se0;
    line_oe  <= next_line_oe;
  end
end

// ----------------------------------------------------------------------
// Receive side pacing
// ----------------------------------------------------------------------
// The elasticity buffer sits in the recovery front end; this block only
// presents bytes it hands over, one strobe per byte regardless of rate.
always @(posedge core_clk)
begin
  if (!rst_n)
  begin
    rx_active <= 1'b0;
    rx_valid  <= 1'b0;
  end
  else
  begin
    rx_active <= rx_packet;
    rx_valid  <= rx_packet && rx_byte_ready;
  end
end

// ----------------------------------------------------------------------
// Receive data holding register
// ----------------------------------------------------------------------
// The byte stays put between strobes, so a slow full speed byte time
// shows the same value for all of its cycles.
always @(posedge core_clk)
begin
  if (!rst_n)
    data_out <= 8'h0;
  else if (rx_packet && rx_byte_ready)
    data_out <= rx_byte;
end

// ----------------------------------------------------------------------
// Data bus direction
// ----------------------------------------------------------------------
always @(posedge core_clk)
begin
  if (!rst_n)
    data_oe <= 1'b0;
  else
    data_oe <= !tx_valid && rx_packet;
end

endmodule

// File: utl_tx_link_props.sv
// Port timing assertions for the transmit link block.
// Assumes a bind to every utl_tx_link instance and a synchronous reset.
`timescale 1ns/1ps
module utl_tx_link_props (
  input wire core_clk,
  input wire rst_n,
  input wire suspend_n,
  input wire xcvr_select,
  input wire tx_valid,
  input wire rx_byte_ready,
  input wire rx_packet,
  input wire tx_ready,
  input wire rx_active,
  input wire rx_valid,
  input wire data_oe,
  input wire phy_byte_clock,
  input wire clock_locked,
  input wire line_se0
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_reset_holds_ready: assert property (disable iff (1'b0)
    !rst_n |=> !tx_ready) else $error("ready during reset");
  a_rx_strobe: assert property (rx_packet && rx_byte_ready |=> rx_valid)
    else $error("missing rx strobe");
  a_rx_cause: assert property (rx_valid |-> $past(rx_byte_ready))
    else $error("rx strobe without byte");
  a_frame_follow: assert property (1'b1 |=> rx_active == $past(rx_packet))
    else $error("rx framing wrong");
  a_bus_turn: assert property (1'b1 |=>
    data_oe == ($past(rx_packet) && !$past(tx_valid)))
    else $error("bus direction wrong");
  a_ready_drop: assert property ($fell(tx_valid) |-> !tx_ready)
    else $error("ready after end");
  a_ready_once: assert property (tx_ready && tx_valid |=> !tx_ready)
    else $error("ready held");
  a_fs_spacing: assert property (tx_ready && tx_valid && xcvr_select
    |=> !tx_ready [*8]) else $error("fs ready too soon");
  a_eop_fs_len: assert property ($rose(line_se0) && xcvr_select |->
    line_se0 [*8] ##1 line_se0 [*2] ##1 !line_se0)
    else $error("fs eop length");
  a_byte_clk_runs: assert property (clock_locked && suspend_n |=>
    phy_byte_clock != $past(phy_byte_clock)) else $error("byte clock stuck");
  a_suspend_unlock: assert property (!suspend_n |=> !clock_locked)
    else $error("locked while suspended");
endmodule
bind utl_tx_link utl_tx_link_props chk_u (.core_clk, .rst_n, .suspend_n,
  .xcvr_select, .tx_valid, .rx_byte_ready, .rx_packet, .tx_ready, .rx_active,
  .rx_valid, .data_oe, .phy_byte_clock, .clock_locked, .line_se0);

// File: utl_sie_model.sv
// Serial interface engine model that sends one packet per go pulse.
// Assumes the link takes a byte on any edge with tx_ready and tx_valid.
`timescale 1ns/1ps
module utl_sie_model (
  input  wire       core_clk,
  input  wire       go,
  input  wire [7:0] base,
  input  wire [3:0] len,
  input  wire       tx_ready,
  output reg        tx_valid,
  output reg  [7:0] data_in,
  output reg  [3:0] taken
);
  initial
  begin
    tx_valid = 1'b0;
    data_in = 8'h00;
    taken = 4'h0;
  end
  // Idle data is inverted so a stale byte can never look valid.
  always @(posedge core_clk)
    if (go && !tx_valid)
    begin
      tx_valid <= 1'b1;
      data_in <= base;
      taken <= 4'h0;
    end
    else if (tx_valid && tx_ready)
    begin
      taken <= taken + 4'h1;
      if (taken + 4'h1 == len)
      begin
        tx_valid <= 1'b0;
        data_in <= ~data_in;
      end
      else
        data_in <= base + {4'h0, taken} + 8'h01;
    end
endmodule

// File: utl_tx_link_bench.sv
// Self-checking bench for the transmit link block.
// Assumes the SIE model file and the checker are compiled first.
`timescale 1ns/1ps
module utl_tx_link_bench;
  reg        core_clk, rst_n, suspend_n, xcvr_select, go;
  reg        rx_byte_ready, rx_packet;
  reg  [7:0] rx_byte, base;
  reg  [3:0] len;
  wire [7:0] data_in, data_out;
  wire [3:0] taken;
  wire       tx_valid, tx_ready, rx_active, rx_valid, data_oe, line_oe;
  wire       phy_byte_clock, clock_locked, line_bit, line_se0;
  integer    num_errors, n_checks, n, last, k, s;
  utl_tx_link #(.START_CYC(10), .SETTLE_CYC(5)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .suspend_n(suspend_n), .xcvr_select(xcvr_select),
    .data_in(data_in), .tx_valid(tx_valid), .rx_byte_ready(rx_byte_ready),
    .rx_byte(rx_byte), .rx_packet(rx_packet), .data_out(data_out),
    .data_oe(data_oe), .tx_ready(tx_ready), .rx_active(rx_active),
    .rx_valid(rx_valid), .phy_byte_clock(phy_byte_clock),
    .clock_locked(clock_locked), .line_bit(line_bit),
    .line_se0(line_se0), .line_oe(line_oe));
  utl_sie_model sie_u (.core_clk(core_clk), .go(go), .base(base), .len(len),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .data_in(data_in),
    .taken(taken));
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // A request made while suspended must wait for the clock start-up.
  task t_clock;
    begin
      @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      for (n = 0; n < 8; n = n + 1)
        @(negedge core_clk) check(tx_ready, 1'b0);
      @(posedge core_clk);
      suspend_n <= 1'b1;
      for (n = 0; n < 100 && !clock_locked; n = n + 1)
        @(negedge core_clk);
      check(n >= 15 && n <= 18, 1'b1);
      last = phy_byte_clock;
      @(negedge core_clk) check(phy_byte_clock, !last);
      for (n = 0; n < 400 && tx_valid; n = n + 1)
        @(negedge core_clk);
      check(taken, len);
      for (n = 0; n < 400 && line_oe; n = n + 1)
        @(negedge core_clk);
      check(line_oe, 1'b0);
      $display("clock test done");
    end
  endtask
  task t_tx(input fs, input [15:0] gap, input [15:0] se0);
    begin
      @(posedge core_clk);
      xcvr_select <= fs;
      len <= 4'h4;
      repeat (20) @(posedge core_clk);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      last = 0;
      k = 0;
      s = 0;
      for (n = 0; n < 700; n = n + 1)
      begin
        @(negedge core_clk);
        if (tx_ready && tx_valid)
        begin
          if (k >= 2)
            check(n - last, gap);
          last = n;
          k = k + 1;
        end
        if (line_se0)
          s = s + 1;
      end
      check(k, 4);
      check(s, se0);
      check(line_bit, 1'b1);
      $display("tx test done");
    end
  endtask
  task t_rx;
    begin
      @(posedge core_clk);
      rx_packet <= 1'b1;
      rx_byte <= 8'h5a;
      rx_byte_ready <= 1'b1;
      @(posedge core_clk);
      rx_byte_ready <= 1'b0;
      @(negedge core_clk) check(rx_valid, 1'b1);
      check(data_out, 8'h5a);
      check(data_oe, 1'b1);
      @(negedge core_clk) check(rx_valid, 1'b0);
      check(rx_active, 1'b1);
      @(posedge core_clk);
      rx_packet <= 1'b0;
      @(posedge core_clk);
      @(negedge core_clk) check(rx_active, 1'b0);
      check(data_oe, 1'b0);
      $display("rx test done");
    end
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial
  begin
    {rst_n, suspend_n, xcvr_select, go, rx_byte_ready, rx_packet} = 6'h00;
    {rx_byte, base, len, num_errors, n_checks} = 0;
    base = 8'h00;
    len = 4'h1;
    repeat (10) @(posedge core_clk);
    check(tx_ready, 1'b0);
    rst_n <= 1'b1;
    @(negedge core_clk) check(line_bit, 1'b1);
    t_clock;
    t_tx(1'b1, 16'd40, 16'd10);
    t_tx(1'b0, 16'd8, 16'd2);
    t_rx;
    report_and_stop;
  end
endmodule
